// file: hdl/wdt_pkg.sv
// Purpose: constants for the watchdog timer block
// Assumes: one system clock, 8-bit control register
// Notes: offsets and field positions live here; the read port packs the fields by fixed position
package wdt_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] WDT_CTRL_ADDR = 8'hD2; // watchdog_control
	localparam int WDT_PRE_LSB = 0; // tick_divider_select low bit
	localparam int WDT_KICK_BIT = 2; // dog_kick
	localparam int WDT_EN_BIT = 3; // enable
	localparam int WDT_UNLOCK_BIT = 4; // stop_unlock
	localparam logic [1:0] WDT_PRE_RST = 2'h3; // longest division
	localparam logic WDT_EN_RST = 1'h1; // running after reset
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int WDT_BASE_SHIFT = 11; // 2048 = 2**11
	localparam int WDT_PRE_W = 14; // covers 16384
	localparam int WDT_CNT_W = 8; // 256 ticks to overflow
	localparam int WDT_UNLOCK_CYC = 16; // unlock window in clocks
	localparam logic [4:0] WDT_UNLOCK_INIT = 5'h10; // window start
endpackage : wdt_pkg

// file: hdl/wdt_timer.sv
// Purpose: 8-bit watchdog with prescaler and keyed disable
// Assumes: register port synchronous to i_clk, 20 MHz clock
// Notes: o_sys_rst is a one-cycle pulse on counter overflow
`timescale 1ns/100ps
`default_nettype none
module wdt_timer
#(
	parameter int CNT_W = wdt_pkg::WDT_CNT_W // 2**CNT_W ticks to overflow
)
(
	input wire logic i_clk, // system clock
	input wire logic i_rst_b, // async reset, active low
	input wire logic [7:0] i_addr, // register address
	input wire logic [7:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	input wire logic i_pdown, // device in power-down
	output logic [7:0] o_rdata, // read data, one cycle later
	output logic o_sys_rst // overflow reset pulse
);
	import wdt_pkg::*;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// one register lives on this port; both strobes share the match
	function automatic logic wdt_ctrl_hit(input logic [7:0] addr);
		return addr == WDT_CTRL_ADDR;
	endfunction : wdt_ctrl_hit

	logic ctrl_wr; // write to control register
	assign ctrl_wr = i_wr && wdt_ctrl_hit(i_addr);

	logic en_reg; // watchdog enable
	logic unlock_reg; // stop_unlock bit
	logic [1:0] pre_sel_reg; // tick_divider_select
	logic [4:0] unlock_win_reg; // clocks left in unlock window
	logic [WDT_PRE_W-1:0] pre_cnt_reg; // prescaler
	logic [CNT_W-1:0] cnt_reg; // watchdog counter
	logic kick; // software kick this cycle
	logic tick; // divided clock tick
	logic [WDT_PRE_W-1:0] pre_top; // last prescaler value

	assign kick = ctrl_wr && i_wdata[WDT_KICK_BIT];

	// a divider lowered mid-count runs to wrap once, so only that one
	// interval is stretched; a kick with the new divider avoids it
	// terminal count: 2**(11+sel) - 1
	assign pre_top = WDT_PRE_W'((32'h1 << (WDT_BASE_SHIFT
		+ int'(pre_sel_reg))) - 1);
	assign tick = (pre_cnt_reg == pre_top);

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	// enable accepts a set any time, a clear only when unlocked
	// a write carrying the key and a clear together counts only an earlier key: key first
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			en_reg <= WDT_EN_RST;
			pre_sel_reg <= WDT_PRE_RST;
			unlock_reg <= 1'h0;
		end
		else if (ctrl_wr)
		begin
			pre_sel_reg <= i_wdata[WDT_PRE_LSB+:2];
			unlock_reg <= i_wdata[WDT_UNLOCK_BIT];
			if (i_wdata[WDT_EN_BIT])
			begin
				en_reg <= 1'h1;
			end
			else if (unlock_win_reg != 5'h0)
			begin
				en_reg <= 1'h0;
			end
		end
	end

	// unlock window opens on writing stop_unlock, then runs down
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			unlock_win_reg <= 5'h0;
		end
		else if (ctrl_wr && i_wdata[WDT_UNLOCK_BIT])
		begin
			unlock_win_reg <= WDT_UNLOCK_INIT;
		end
		else if (unlock_win_reg != 5'h0)
		begin
			unlock_win_reg <= unlock_win_reg - 5'h1;
		end
	end

	// ------------------------------------------------------------
	// prescaler and counter
	// ------------------------------------------------------------
	// held clear while off so a re-enable gives a full interval
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			pre_cnt_reg <= '0;
			cnt_reg <= '0;
		end
		else if (!en_reg || kick)
		begin
			pre_cnt_reg <= '0;
			cnt_reg <= '0;
		end
		else if (!i_pdown) // frozen in power-down
		begin
			pre_cnt_reg <= tick ? '0 : pre_cnt_reg + WDT_PRE_W'(1);
			if (tick)
			begin
				cnt_reg <= cnt_reg + CNT_W'(1); // wraps
			end
		end
	end

	// overflow pulse after 256 ticks
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_sys_rst <= 1'h0;
		end
		else
		begin
			o_sys_rst <= en_reg && !kick && !i_pdown && tick
				&& (cnt_reg == '1);
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// kick reads zero, reserved bits zero, unmapped reads zero
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_rdata <= 8'h00;
		end
		else if (i_rd && wdt_ctrl_hit(i_addr))
		begin
			o_rdata <= {3'h0, unlock_reg, en_reg, 1'h0, pre_sel_reg};
		end
		else
		begin
			o_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// all checks share the one clock and are quiet during reset
	a_locked_clear: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(ctrl_wr && !i_wdata[WDT_EN_BIT] && unlock_win_reg == 5'h0
		&& en_reg) |=> en_reg)
		else $error("enable cleared without unlock");
	a_set_enable: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(ctrl_wr && i_wdata[WDT_EN_BIT]) |=> en_reg)
		else $error("enable write ignored");
	a_kick_clears: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		kick |=> (cnt_reg == '0 && pre_cnt_reg == '0))
		else $error("kick did not clear counter");
	a_kick_reads0: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		i_rd |=> !o_rdata[WDT_KICK_BIT])
		else $error("kick bit read as one");
	a_off_held: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(!en_reg ##1 !en_reg) |-> (cnt_reg == '0))
		else $error("counter moved while disabled");
	a_no_rst_off: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		!$past(en_reg) |-> !o_sys_rst)
		else $error("reset while disabled");
	a_pdown_freeze: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_pdown && !kick && en_reg) |=> $stable(cnt_reg))
		else $error("counted in power-down");
	a_ovf_cause: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		o_sys_rst |-> ($past(cnt_reg) == '1 && cnt_reg == '0))
		else $error("reset without overflow");
	a_tick_top: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(pre_sel_reg == 2'h0 && tick) |-> pre_cnt_reg == 14'h07FF)
		else $error("wrong divide");
	a_pulse_single: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		o_sys_rst |=> !o_sys_rst)
		else $error("reset pulse longer than one cycle");
	a_window_open: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(ctrl_wr && i_wdata[WDT_UNLOCK_BIT]) |=>
		(unlock_win_reg == WDT_UNLOCK_INIT))
		else $error("unlock window not opened");
endmodule : wdt_timer
`default_nettype wire

// file: sim/tb_top.sv
// Purpose: self-checking bench for the watchdog control register
// Assumes: 20 MHz clock, reads answer one cycle after the strobe
// Notes: the counter is built two bits wide here so that overflow
// fits the run; expected timeouts scale from the same formula
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import wdt_pkg::*;
	// ------------------------------------------------------------
	// stimulus and observation signals
	// ------------------------------------------------------------
	logic i_clk = 1'h0; // system clock
	logic i_rst_b = 1'h0; // reset, active low
	logic [7:0] i_addr = 8'h00; // register address
	logic [7:0] i_wdata = 8'h00; // write data
	logic i_wr = 1'h0; // write strobe
	logic i_rd = 1'h0; // read strobe
	logic i_pdown = 1'h0; // power-down level
	logic [7:0] o_rdata; // read data
	logic o_sys_rst; // overflow pulse
	int mismatches = 0; // failed compares
	int checks = 0; // compares made
	logic expect_ovf = 1'h0; // an overflow pulse is wanted now
	localparam int TB_CNT_W = 2; // short counter keeps runs brief
	// clocks from a kick to the last tick at divide 2048
	localparam int OVF_CYC = 1 << (TB_CNT_W + WDT_BASE_SHIFT);
	always #25 i_clk = ~i_clk;
	wdt_timer #(.CNT_W(TB_CNT_W)) wdt_timer_i (.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_pdown(i_pdown), .o_rdata(o_rdata), .o_sys_rst(o_sys_rst));
	// ------------------------------------------------------------
	// compare, bus tasks and closing report
	// ------------------------------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task chk_cnt(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_cnt
	// one-cycle write strobe; releasing it costs the next edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'h0;
	endtask : wr
	// data stand only in the cycle after the strobe: sample mid-cycle
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'h0;
		@(negedge i_clk);
		chk(o_rdata, exp);
	endtask : rd
	// kick with data d, freeze for hold clocks, then time the pulse;
	// n counts falling edges from the kick, so the pulse shows at
	// the timeout plus the freeze plus one
	task ovf(input logic [7:0] d, input int hold, input int exp);
		int n;
		logic seen;
		n = 0;
		seen = 1'h0;
		expect_ovf = 1'h1;
		wr(WDT_CTRL_ADDR, d);
		i_pdown <= (hold > 0);
		while (!seen && n < 40000)
		begin
			@(negedge i_clk);
			n++;
			seen = (o_sys_rst === 1'h1);
			if (!seen)
			begin
				@(posedge i_clk);
				if (n == hold)
					i_pdown <= 1'h0;
			end
		end
		chk_cnt(n, exp);
		@(posedge i_clk);
		@(negedge i_clk);
		chk({7'h00, o_sys_rst}, 8'h00);
		expect_ovf = 1'h0;
	endtask : ovf
	task results;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// outside the overflow timing tests no pulse may appear
	always @(negedge i_clk)
		if (i_rst_b && !expect_ovf && o_sys_rst !== 1'h0)
			chk({7'h00, o_sys_rst}, 8'h00);
	// hang guard
	initial
	begin
		repeat (100000) @(posedge i_clk);
		mismatches++;
		results();
	end
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge i_clk);
		i_rst_b <= 1'h1;
		rd(WDT_CTRL_ADDR, 8'h0B);
		rd(8'h00, 8'h00);
		$display("test reset values done");
		// kick bit never reads back, every divider code is kept
		wr(WDT_CTRL_ADDR, 8'h0C);
		rd(WDT_CTRL_ADDR, 8'h08);
		i_pdown <= 1'h1;
		for (int p = 0; p < 4; p++)
		begin
			wr(WDT_CTRL_ADDR, 8'h0C | 8'(p));
			rd(WDT_CTRL_ADDR, 8'h08 | 8'(p));
		end
		i_pdown <= 1'h0;
		$display("test kick and divider done");
		// clearing enable without the key is refused
		wr(WDT_CTRL_ADDR, 8'h03);
		rd(WDT_CTRL_ADDR, 8'h0B);
		// key gone stale is refused: clear lands 17 clocks after it
		wr(WDT_CTRL_ADDR, 8'h1B);
		rd(WDT_CTRL_ADDR, 8'h1B);
		repeat (13) @(posedge i_clk);
		wr(WDT_CTRL_ADDR, 8'h03);
		rd(WDT_CTRL_ADDR, 8'h0B);
		// key then clear, back to back, stops the dog
		wr(WDT_CTRL_ADDR, 8'h13);
		wr(WDT_CTRL_ADDR, 8'h03);
		rd(WDT_CTRL_ADDR, 8'h03);
		// enabling needs no key; stray address writes are dropped
		wr(WDT_CTRL_ADDR, 8'h08);
		wr(8'h00, 8'hFF);
		rd(WDT_CTRL_ADDR, 8'h08);
		// key, then clear on the sixteenth clock: still inside
		wr(WDT_CTRL_ADDR, 8'h18);
		repeat (14) @(posedge i_clk);
		wr(WDT_CTRL_ADDR, 8'h00);
		rd(WDT_CTRL_ADDR, 8'h00);
		wr(WDT_CTRL_ADDR, 8'h08);
		$display("test keyed disable done");
		// overflow timing: plain, frozen for a while, longer divide
		ovf(8'h0C, 0, OVF_CYC + 1);
		ovf(8'h0C, 500, OVF_CYC + 501);
		ovf(8'h0D, 0, 2 * OVF_CYC + 1);
		$display("test overflow timing done");
		results();
	end
endmodule : tb_top
`default_nettype wire
